/* plf_link_fault_ctrl.sv */
// PHY link fault control: control registers, tx odd nibble, RMII sampling, fast link down
// Functional notes
// - Flag receive symbol errors in idle only while idle error detect bit set.
// - Odd-nibble tx enable drop is stretched one tx clock, flagged as error.
// - RMII receive data sampled on rx clock if select is 1, else crystal.
// - Link fault control bits 15:11 and 9:7 ignore writes, read zero.
// - Descrambler lock loss drops the link only when its enable is set.
// - Polarity bit 1 is normal, 0 inverts both pairs.
// - Pair swap bit 1 exchanges transmit and receive pairs.
// - Port mirroring only when both swap and polarity bits are high.
// - Rx error drop after 32 errors inside a 10 us window.
// - MLT3 violation drop after 20 violations inside a 10 us window.
// - Low SNR drop after 20 threshold crossings inside a 10 us window.
// - Energy loss drops the link immediately when enabled.
// - Link drop is the OR of the five enabled criteria, all reset off.
// - Each criterion causing a drop latches its read-only status flag.
//
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
module plf_link_fault_ctrl
    import plf_pkg::*;
(
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Wishbone slave
    input  wire logic         wb_cyc_i,
    input  wire logic         wb_stb_i,
    input  wire logic         wb_we_i,
    input  wire logic [7:0]   wb_adr_i,
    input  wire logic [3:0]   wb_sel_i,
    input  wire logic [31:0]  wb_dat_i,
    output logic      [31:0]  wb_dat_o,
    output logic              wb_ack_o,
    // MII transmit pins
    input  wire logic         tx_clk_i,
    input  wire logic         tx_en_i,
    input  wire logic         tx_er_i,
    output logic              tx_en_o,
    output logic              tx_er_o,
    // RMII receive pins
    input  wire logic         rmii_mode_i,
    input  wire logic         rx_clk_i,
    input  wire logic         crystal_input_clock_i,
    input  wire logic [1:0]   rxd_i,
    output logic      [1:0]   rmii_rxd_o,
    output logic              rmii_rxd_vld_o,
    // Receive idle symbol errors
    input  wire logic         rx_idle_i,
    input  wire logic         rx_sym_err_i,
    output logic              idle_sym_err_o,
    // Pair control
    output logic              pol_invert_o,
    output logic              pair_crossover_select_o,
    output logic              port_mirror_o,
    // Fast link down
    input  wire plf_fld_evt_t fld_evt_i,
    output logic              link_drop_o
);
    typedef struct packed {
        logic [2:0]       gen;
        logic [15:0]      lfc;
        logic [4:0]       qds;
        logic             ack;
        logic [31:0]      dat;
        logic             txc_d;
        logic             odd;
        logic             tx_en;
        logic             tx_er;
        logic             rxc_d;
        logic             xic_d;
        logic [1:0]       rxd;
        logic             rxd_vld;
        logic             idle_err;
        logic [WIN_W-1:0] win_cnt;
        logic             win_clr;
        logic             drop;
    } plf_top_st_t;

    plf_top_st_t  r;
    plf_top_st_t  nxt;
    logic [6:0]   pins_s;
    logic         txc_s;
    logic         tx_en_s;
    logic         tx_er_s;
    logic         rxc_s;
    logic         xic_s;
    logic [1:0]   rxd_s;
    logic [2:0]   hit;
    logic [4:0]   cause;
    logic         req;
    logic         tx_rise;
    logic         rx_rise;
    logic [15:0]  bmask;
    logic [15:0]  rd_val;
    logic [5:0]   idx;

    // Tx clock, enable and error, rx clock, crystal and rxd pins pass the same two stages so data stays aligned with its clock
    plf_sync #(.W(7)) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({tx_clk_i, tx_en_i, tx_er_i, rx_clk_i, crystal_input_clock_i, rxd_i}),
        .q_o   (pins_s)
    );
    assign {txc_s, tx_en_s, tx_er_s, rxc_s, xic_s, rxd_s} = pins_s;

    // Windowed counters: rx errors, MLT3 violations, low SNR crossings
    localparam int LIM [3] = '{RXERR_LIMIT, MLT3_LIMIT, SNR_LIMIT};
    logic [2:0] cnt_evt;
    assign cnt_evt = {fld_evt_i.rxerr, fld_evt_i.mlt3, fld_evt_i.snr};

    for (genvar g = 0; g < 3; g++) begin : g_cnt
        plf_win_cnt #(.LIMIT(LIM[g])) u_cnt (
            .clk_i     (clk_i),
            .rst_i     (rst_i),
            .en_i      (r.lfc[LFC_RXERR_BIT - g]),
            .win_clr_i (r.win_clr),
            .evt_i     (cnt_evt[2 - g]),
            .hit_o     (hit[2 - g])
        );
    end

    assign cause = {fld_evt_i.descr & r.lfc[LFC_DESCR_BIT], hit,
                    fld_evt_i.energy & r.lfc[LFC_ENERGY_BIT]};

    assign idx     = wb_adr_i[7:2];
    assign req     = wb_cyc_i && wb_stb_i && !r.ack;
    assign bmask   = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign tx_rise = txc_s && !r.txc_d;
    assign rx_rise = r.gen[GEN_RXCLK_SEL_BIT] ? (rxc_s && !r.rxc_d) : (xic_s && !r.xic_d);

    always_comb begin
        rd_val = 16'h0000;
        unique case (idx)
            IDX_GEN_CTRL:   rd_val = {13'h0000, r.gen};
            IDX_LINK_FAULT: rd_val = r.lfc & LFC_WR_MASK;
            IDX_QUICK_DROP: rd_val = {7'h00, r.qds, 4'h0};
            default:        rd_val = 16'h0000;
        endcase
    end

    always_comb begin
        nxt     = r;
        nxt.ack = req;
        // Status flags: a drop in the clearing cycle still latches
        nxt.qds = r.qds | cause;
        if (req) begin
            nxt.dat = {16'h0000, rd_val};
            if (wb_we_i) begin
                if (idx == IDX_GEN_CTRL) begin
                    nxt.gen = ((r.gen & ~bmask[2:0]) | (wb_dat_i[2:0] & bmask[2:0])) & GEN_WR_MASK[2:0];
                end
                if (idx == IDX_LINK_FAULT) begin
                    nxt.lfc = ((r.lfc & ~bmask) | (wb_dat_i[15:0] & bmask)) & LFC_WR_MASK;
                end
            end else if (idx == IDX_QUICK_DROP) begin
                nxt.qds = cause;
            end
        end

        // Transmit enable, evaluated once per tx clock rising edge
        nxt.txc_d = txc_s;
        if (tx_rise) begin
            if (tx_en_s) begin
                nxt.tx_en = 1'b1;
                nxt.tx_er = tx_er_s;
                nxt.odd   = ~r.odd;
            end else if (r.tx_en && r.odd && !r.gen[GEN_ODD_DIS_BIT]) begin
                nxt.tx_en = 1'b1;
                nxt.tx_er = 1'b1;
                nxt.odd   = 1'b0;
            end else begin
                nxt.tx_en = 1'b0;
                nxt.tx_er = 1'b0;
                nxt.odd   = 1'b0;
            end
        end

        // RMII receive sampling on the selected reference
        nxt.rxc_d   = rxc_s;
        nxt.xic_d   = xic_s;
        nxt.rxd_vld = rmii_mode_i && rx_rise;
        if (rmii_mode_i && rx_rise) begin
            nxt.rxd = rxd_s;
        end

        nxt.idle_err = r.gen[GEN_IDLE_ERR_BIT] && rx_idle_i && rx_sym_err_i;

        // Free running window so counters see fixed boundaries
        if (r.win_cnt == WIN_W'(WIN_CYC - 1)) begin
            nxt.win_cnt = '0;
            nxt.win_clr = 1'b1;
        end else begin
            nxt.win_cnt = r.win_cnt + 1'b1;
            nxt.win_clr = 1'b0;
        end

        nxt.drop = |cause;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r     <= '0;
            r.gen <= GEN_RST[2:0];
            r.lfc <= LFC_RST;
        end else begin
            r <= nxt;
        end
    end

    assign wb_ack_o                = r.ack;
    assign wb_dat_o                = r.dat;
    assign tx_en_o                 = r.tx_en;
    assign tx_er_o                 = r.tx_er;
    assign rmii_rxd_o              = r.rxd;
    assign rmii_rxd_vld_o          = r.rxd_vld;
    assign idle_sym_err_o          = r.idle_err;
    assign link_drop_o             = r.drop;
    assign pol_invert_o            = ~r.lfc[LFC_POL_BIT];
    assign pair_crossover_select_o = r.lfc[LFC_SWAP_BIT];
    assign port_mirror_o           = r.lfc[LFC_SWAP_BIT] & r.lfc[LFC_POL_BIT];

    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence

    sequence s_lfc_both_write;
        s_req and (wb_we_i && wb_sel_i[0] && (idx == IDX_LINK_FAULT)
            && wb_dat_i[LFC_SWAP_BIT] && wb_dat_i[LFC_POL_BIT]);
    endsequence

    property p_ack_one;
        @(posedge clk_i) disable iff (rst_i)
        s_req |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("bus ack not a single cycle");

    property p_idle_err;
        @(posedge clk_i) disable iff (rst_i)
        idle_sym_err_o |-> $past(r.gen[GEN_IDLE_ERR_BIT]) && $past(rx_idle_i) && $past(rx_sym_err_i);
    endproperty
    a_idle_err: assert property (p_idle_err) else $error("idle error flag without cause");

    property p_odd_stretch;
        @(posedge clk_i) disable iff (rst_i)
        (tx_rise && !tx_en_s && tx_en_o && r.odd && !r.gen[GEN_ODD_DIS_BIT]) |=> tx_en_o && tx_er_o;
    endproperty
    a_odd_stretch: assert property (p_odd_stretch) else $error("odd nibble drop not stretched");

    property p_rmii_src;
        @(posedge clk_i) disable iff (rst_i)
        rmii_rxd_vld_o |-> $past(rmii_mode_i) && ($past(r.gen[GEN_RXCLK_SEL_BIT]) ? $past(rxc_s) : $past(xic_s));
    endproperty
    a_rmii_src: assert property (p_rmii_src) else $error("rmii sample on wrong clock");

    property p_rsvd_zero;
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o && $past(idx == IDX_LINK_FAULT) |-> (wb_dat_o[15:11] == 5'h00) && (wb_dat_o[9:7] == 3'h0);
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits read nonzero");

    property p_descr_drop;
        @(posedge clk_i) disable iff (rst_i)
        fld_evt_i.descr && r.lfc[LFC_DESCR_BIT] |=> link_drop_o && r.qds[4];
    endproperty
    a_descr_drop: assert property (p_descr_drop) else $error("descrambler loss did not drop");

    property p_mirror;
        @(posedge clk_i) disable iff (rst_i)
        s_lfc_both_write |=> port_mirror_o && !pol_invert_o && pair_crossover_select_o;
    endproperty
    a_mirror: assert property (p_mirror) else $error("mirror not enabled by both bits");

    property p_drop_or;
        @(posedge clk_i) disable iff (rst_i)
        link_drop_o |-> $past(|cause);
    endproperty
    a_drop_or: assert property (p_drop_or) else $error("link drop without enabled cause");

    property p_window;
        @(posedge clk_i) disable iff (rst_i)
        r.win_clr |-> (r.win_cnt == '0) ##1 !r.win_clr [*8];
    endproperty
    a_window: assert property (p_window) else $error("window boundary misplaced");

    property p_energy_drop;
        @(posedge clk_i) disable iff (rst_i)
        fld_evt_i.energy && r.lfc[LFC_ENERGY_BIT] |=> link_drop_o && r.qds[0];
    endproperty
    a_energy_drop: assert property (p_energy_drop) else $error("energy loss did not drop");

    property p_cnt_drop;
        @(posedge clk_i) disable iff (rst_i)
        (|hit) |=> link_drop_o && ((r.qds[3:1] & $past(hit)) == $past(hit));
    endproperty
    a_cnt_drop: assert property (p_cnt_drop) else $error("counter hit did not drop");

    property p_qds_hold;
        @(posedge clk_i) disable iff (rst_i)
        !(req && !wb_we_i && (idx == IDX_QUICK_DROP)) |=> ((r.qds & $past(r.qds)) == $past(r.qds));
    endproperty
    a_qds_hold: assert property (p_qds_hold) else $error("status flag lost before read");

    property p_lfc_write;
        @(posedge clk_i) disable iff (rst_i)
        s_req and (wb_we_i && (wb_sel_i[1:0] == 2'h3) && (idx == IDX_LINK_FAULT))
            |=> (r.lfc == ($past(wb_dat_i[15:0]) & LFC_WR_MASK));
    endproperty
    a_lfc_write: assert property (p_lfc_write) else $error("link fault control write wrong");
endmodule

/* plf_link_fault_ctrl_tb_top.sv */
// Self-checking bench for the link fault control block
`timescale 1ns/1ns
module plf_link_fault_ctrl_tb_top
    import plf_pkg::*;
;
    logic         clk_i = 1'b0;
    logic         rst_i = 1'b1;
    logic         wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]   wb_adr_i = 8'h00;
    logic [3:0]   wb_sel_i = 4'h0;
    logic [31:0]  wb_dat_i = 32'h0000_0000;
    logic [31:0]  wb_dat_o;
    logic         wb_ack_o, tx_en_o, tx_er_o, rmii_rxd_vld_o, idle_sym_err_o;
    logic         tx_clk, tx_en, tx_er, rx_clk, xtal, link_drop_o;
    logic         pol_invert_o, pair_crossover_select_o, port_mirror_o;
    logic [1:0]   rxd, rmii_rxd_o;
    logic         rmii_mode_i = 1'b1, rx_idle_i = 1'b0, rx_sym_err_i = 1'b0;
    plf_fld_evt_t fld_evt_i = '0;
    logic         clr_mon = 1'b0, drop_seen, er_seen, idle_seen;
    int           vld_cnt, ten_cnt, step_bad, cyc, failures = 0, cmp_count = 0;
    logic [15:0]  rd;
    logic [1:0]   rxd_last;

    always #10 clk_i = ~clk_i;

    plf_mac_model i_mac (.tx_clk_o(tx_clk), .tx_en_o(tx_en), .tx_er_o(tx_er),
        .rx_clk_o(rx_clk), .xtal_o(xtal), .rxd_o(rxd));

    plf_link_fault_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_clk_i(tx_clk),
        .tx_en_i(tx_en), .tx_er_i(tx_er), .tx_en_o(tx_en_o), .tx_er_o(tx_er_o),
        .rmii_mode_i(rmii_mode_i), .rx_clk_i(rx_clk), .crystal_input_clock_i(xtal),
        .rxd_i(rxd), .rmii_rxd_o(rmii_rxd_o), .rmii_rxd_vld_o(rmii_rxd_vld_o),
        .rx_idle_i(rx_idle_i), .rx_sym_err_i(rx_sym_err_i), .idle_sym_err_o(idle_sym_err_o),
        .pol_invert_o(pol_invert_o), .pair_crossover_select_o(pair_crossover_select_o),
        .port_mirror_o(port_mirror_o), .fld_evt_i(fld_evt_i), .link_drop_o(link_drop_o));

    // Sticky monitors so short pulses are not missed between checks
    always @(posedge clk_i) begin
        cyc <= rst_i ? 0 : cyc + 1;
        if (clr_mon) begin
            drop_seen <= 1'b0;
            er_seen   <= 1'b0;
            idle_seen <= 1'b0;
            vld_cnt   <= 0;
            ten_cnt   <= 0;
            step_bad  <= 0;
        end else begin
            drop_seen <= drop_seen | link_drop_o;
            er_seen   <= er_seen | tx_er_o;
            idle_seen <= idle_seen | idle_sym_err_o;
            vld_cnt   <= vld_cnt + int'(rmii_rxd_vld_o);
            ten_cnt   <= ten_cnt + int'(tx_en_o);
            step_bad  <= step_bad + int'(rmii_rxd_vld_o && vld_cnt > 0 && rmii_rxd_o != rxd_last + 2'h1);
        end
        if (rmii_rxd_vld_o)
            rxd_last <= rmii_rxd_o;
    end

    task automatic stop_test;
        $display("checks %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", name, exp, got);
            failures++;
        end
    endtask

    // One classic Wishbone cycle; ack and read data taken at the same rising edge
    task automatic wb(input logic we, input logic [7:0] adr, input logic [15:0] d);
        int i;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'h3;
        wb_dat_i <= {16'h0000, d};
        for (i = 0; i < 16; i++) begin
            @(posedge clk_i);
            if (wb_ack_o === 1'b1)
                break;
        end
        if (i == 16) begin
            $display("[ERR] wb ack expected 1 seen 0");
            failures++;
            stop_test();
        end
        rd = wb_dat_o[15:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic clr;
        @(posedge clk_i);
        clr_mon <= 1'b1;
        @(posedge clk_i);
        clr_mon <= 1'b0;
    endtask

    task automatic pulse(input plf_fld_evt_t e, input int n);
        repeat (n) begin
            @(posedge clk_i);
            fld_evt_i <= e;
        end
        @(posedge clk_i);
        fld_evt_i <= '0;
        repeat (4) @(posedge clk_i);
    endtask

    // Align to a point early inside a 500-cycle window
    task automatic wait_win;
        int i;
        for (i = 0; i < 600; i++) begin
            @(posedge clk_i);
            if (cyc % WIN_CYC == 40)
                break;
        end
        if (i == 600) begin
            $display("[ERR] window align expected 40 seen none");
            failures++;
            stop_test();
        end
    endtask

    task automatic t_regs;
        wb(0, 8'h28, 16'h0000); chk("gen rst", GEN_RST, rd);
        wb(0, 8'h2C, 16'h0000); chk("lfc rst", LFC_RST, rd);
        wb(0, 8'h3C, 16'h0000); chk("qds rst", 16'h0000, rd);
        wb(1, 8'h00, 16'hFFFF);
        wb(0, 8'h00, 16'h0000); chk("unmapped", 16'h0000, rd);
        wb(1, 8'h2C, 16'hFFFF);
        wb(0, 8'h2C, 16'h0000); chk("lfc rsv", 16'h047F, rd);
        chk("pol", 16'h0000, {15'h0, pol_invert_o});
        chk("mirror", 16'h0001, {15'h0, port_mirror_o});
        wb(1, 8'h2C, 16'h0020); // Swap alone, mirror not requested
        wb(0, 8'h2C, 16'h0000);
        chk("pol1", 16'h0001, {15'h0, pol_invert_o});
        chk("swap", 16'h0001, {15'h0, pair_crossover_select_o});
        chk("mirror0", 16'h0000, {15'h0, port_mirror_o});
        wb(1, 8'h2C, 16'h0040);
        wb(0, 8'h2C, 16'h0000);
        chk("swap0", 16'h0000, {15'h0, pair_crossover_select_o});
        chk("mirror00", 16'h0000, {15'h0, port_mirror_o});
        wb(1, 8'h2C, 16'h0000);
    endtask

    task automatic t_idle_err;
        rx_idle_i <= 1'b1;
        for (int en = 1; en >= 0; en--) begin
            wb(1, 8'h28, {13'h0, en[0], 2'h0});
            clr();
            @(posedge clk_i) rx_sym_err_i <= 1'b1;
            @(posedge clk_i) rx_sym_err_i <= 1'b0;
            repeat (4) @(posedge clk_i);
            chk("idle err", {15'h0, en[0]}, {15'h0, idle_seen});
        end
    endtask

    task automatic t_odd;
        int dis [3] = '{0, 0, 1};
        int n [3] = '{3, 4, 3};
        for (int k = 0; k < 3; k++) begin
            wb(1, 8'h28, {14'h1, dis[k][0], 1'b0});
            clr();
            i_mac.send(n[k]);
            repeat (60) @(posedge clk_i);
            chk("odd er", {15'h0, k == 0}, {15'h0, er_seen});
            // Eight system clocks per nibble, one extra nibble when stretched
            chk("odd len", 16'(8 * (n[k] + int'(k == 0))), 16'(ten_cnt));
        end
    endtask

    task automatic t_rmii;
        for (int s = 1; s >= 0; s--) begin
            wb(1, 8'h28, {14'h1, 1'b0, s[0]});
            clr();
            repeat (160) @(posedge clk_i);
            // 3200 ns: 20 rx clock edges or 16 crystal edges, one edge of slack
            chk("rmii rate", 16'h0001, {15'h0, vld_cnt >= (s ? 19 : 15) && vld_cnt <= (s ? 21 : 17)});
            if (s == 1)
                chk("rmii step", 16'h0000, 16'(step_bad));
        end
        // Mode off: no sample on the crystal reference
        rmii_mode_i <= 1'b0;
        clr();
        repeat (40) @(posedge clk_i);
        chk("rmii off", 16'h0000, 16'(vld_cnt));
        rmii_mode_i <= 1'b1;
    endtask

    task automatic t_level;
        plf_fld_evt_t ev [2] = '{5'b10000, 5'b00001};
        logic [15:0] own [2] = '{16'h0400, 16'h0001};
        logic [15:0] st [2] = '{16'h0100, 16'h0010};
        for (int k = 0; k < 2; k++) begin
            wb(1, 8'h2C, 16'h0401 ^ own[k]);
            clr();
            pulse(ev[k], 6);
            chk("drop off", 16'h0000, {15'h0, drop_seen});
            wb(1, 8'h2C, 16'h0401);
            clr();
            pulse(ev[k], 6);
            chk("drop on", 16'h0001, {15'h0, drop_seen});
            wb(0, 8'h3C, 16'h0000); chk("qds", st[k], rd);
            wb(0, 8'h3C, 16'h0000); chk("qds clr", 16'h0000, rd);
        end
        wb(1, 8'h2C, 16'h0000);
    endtask

    task automatic t_count;
        plf_fld_evt_t ev [3] = '{5'b01000, 5'b00100, 5'b00010};
        int lim [3] = '{RXERR_LIMIT, MLT3_LIMIT, SNR_LIMIT};
        logic [15:0] en [3] = '{16'h0008, 16'h0004, 16'h0002};
        logic [15:0] st [3] = '{16'h0080, 16'h0040, 16'h0020};
        for (int k = 0; k < 3; k++) begin
            wb(1, 8'h2C, 16'h0000);
            wait_win();
            clr();
            pulse(ev[k], lim[k]);
            chk("cnt off", 16'h0000, {15'h0, drop_seen});
            wb(1, 8'h2C, en[k]);
            wait_win();
            clr();
            pulse(ev[k], lim[k] - 1);
            wait_win();
            pulse(ev[k], lim[k] - 1);
            chk("cnt below", 16'h0000, {15'h0, drop_seen});
            pulse(ev[k], 1);
            chk("cnt hit", 16'h0001, {15'h0, drop_seen});
            wb(0, 8'h3C, 16'h0000); chk("qds cnt", st[k], rd);
        end
        wb(1, 8'h2C, 16'h0000);
    endtask

    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_idle_err();
        t_odd();
        t_rmii();
        t_level();
        t_count();
        stop_test();
    end
endmodule

/* plf_mac_model.sv */
// MAC-side partner: MII transmit nibbles, RMII receive clocks and data
`timescale 1ns/1ns
module plf_mac_model #(
    parameter int TX_HALF_NS = 80,
    parameter int XT_HALF_NS = 100
) (
    // MII transmit side
    output logic       tx_clk_o,
    output logic       tx_en_o,
    output logic       tx_er_o,
    // RMII receive side
    output logic       rx_clk_o,
    output logic       xtal_o,
    output logic [1:0] rxd_o
);
    initial begin
        tx_clk_o = 1'b0;
        rx_clk_o = 1'b0;
        xtal_o   = 1'b0;
        tx_en_o  = 1'b0;
        tx_er_o  = 1'b0;
        rxd_o    = 2'h0;
    end
    // Free running clocks, crystal slower so the chosen source shows in rate
    always #(TX_HALF_NS) tx_clk_o = ~tx_clk_o;
    always #(TX_HALF_NS) rx_clk_o = ~rx_clk_o;
    always #(XT_HALF_NS) xtal_o = ~xtal_o;
    // Data moves every cycle so a stale sample cannot pass
    always @(negedge rx_clk_o) rxd_o <= rxd_o + 2'h1;
    // Frame of n nibbles; never flags a transmit error itself
    task automatic send(input int n);
        repeat (n) begin
            @(posedge tx_clk_o);
            tx_en_o <= 1'b1;
        end
        @(posedge tx_clk_o);
        tx_en_o <= 1'b0;
    endtask
endmodule

/* plf_pkg.sv */
// Package: register map, field positions, timing counts and carrier types
package plf_pkg;

    // Timing
    localparam int CLK_MHZ     = 50;
    localparam int WIN_TIME_US = 10;
    localparam int WIN_CYC     = WIN_TIME_US * CLK_MHZ;
    localparam int WIN_W       = $clog2(WIN_CYC);

    // Event thresholds per window
    localparam int RXERR_LIMIT = 32;
    localparam int MLT3_LIMIT  = 20;
    localparam int SNR_LIMIT   = 20;

    // Register indices, byte address is four times the index
    localparam logic [5:0] IDX_GEN_CTRL   = 6'h0A;
    localparam logic [5:0] IDX_LINK_FAULT = 6'h0B;
    localparam logic [5:0] IDX_QUICK_DROP = 6'h0F;

    // General control fields
    localparam int GEN_RXCLK_SEL_BIT = 0;
    localparam int GEN_ODD_DIS_BIT   = 1;
    localparam int GEN_IDLE_ERR_BIT  = 2;
    localparam logic [15:0] GEN_WR_MASK = 16'h0007;
    localparam logic [15:0] GEN_RST     = 16'h0004;

    // Link fault control fields
    localparam int LFC_ENERGY_BIT = 0;
    localparam int LFC_SNR_BIT    = 1;
    localparam int LFC_MLT3_BIT   = 2;
    localparam int LFC_RXERR_BIT  = 3;
    localparam int LFC_SWAP_BIT   = 5;
    localparam int LFC_POL_BIT    = 6;
    localparam int LFC_DESCR_BIT  = 10;
    localparam logic [15:0] LFC_WR_MASK = 16'h047F;
    localparam logic [15:0] LFC_RST     = 16'h0000;

    // Quick drop status flags sit at bits 8:4
    localparam int QDS_LSB = 4;
    localparam int QDS_MSB = 8;

    // Fast link down event bundle, order matches status bits 8 down to 4
    typedef struct packed {
        logic descr;
        logic rxerr;
        logic mlt3;
        logic snr;
        logic energy;
    } plf_fld_evt_t;

endpackage

/* plf_sync.sv */
// Two flip-flop synchroniser for pin-level inputs
`timescale 1ns/1ns
module plf_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Data
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } plf_sync_st_t;

    plf_sync_st_t r;
    plf_sync_st_t nxt;

    always_comb begin
        nxt    = r;
        nxt.s1 = d_i;
        nxt.s2 = r.s1;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '0;
        end else begin
            r <= nxt;
        end
    end

    // Only the second stage leaves the module
    assign q_o = r.s2;
endmodule

/* plf_win_cnt.sv */
// Windowed event counter, pulses once the limit is reached inside a window
`timescale 1ns/1ns
module plf_win_cnt #(
    parameter int LIMIT = 20,
    parameter int CNT_W = $clog2(LIMIT + 1)
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Control
    input  wire logic en_i,
    input  wire logic win_clr_i,
    input  wire logic evt_i,
    // Result
    output logic      hit_o
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             hit;
    } plf_cnt_st_t;

    plf_cnt_st_t r;
    plf_cnt_st_t nxt;

    always_comb begin
        nxt     = r;
        nxt.hit = 1'b0;
        if (!en_i) begin
            nxt.cnt = '0;
        end else if (win_clr_i) begin
            // Event on the boundary opens the new window
            nxt.cnt = evt_i ? CNT_W'(1) : '0;
        end else if (evt_i) begin
            if (r.cnt == CNT_W'(LIMIT - 1)) begin
                nxt.hit = 1'b1;
                nxt.cnt = '0;
            end else begin
                nxt.cnt = r.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '0;
        end else begin
            r <= nxt;
        end
    end

    assign hit_o = r.hit;

    property p_hit_cause;
        @(posedge clk_i) disable iff (rst_i)
        hit_o |-> $past(en_i) && $past(evt_i) && !$past(win_clr_i) && ($past(r.cnt) == CNT_W'(LIMIT - 1));
    endproperty
    a_hit_cause: assert property (p_hit_cause) else $error("counter hit without limit reached");

    property p_no_count_off;
        @(posedge clk_i) disable iff (rst_i)
        !en_i |=> (r.cnt == '0) && !hit_o;
    endproperty
    a_no_count_off: assert property (p_no_count_off) else $error("counter ran while disabled");
endmodule
